// >>> phy_mgmt_pkg.sv
// constants and types for the phy management register access block
// Overview of operation
// - bits 10:6 select target phy register
// - bit 1 chooses write or read
// - cycle starts only when pending written one
// - pending stays set until access completes
// - read data valid when pending clears
// - data low 16 bits carry phy data
// - both registers reset to zero
package phy_mgmt_pkg;
   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_ACCESS_CONTROL = 8'h06;
   localparam logic [7:0] IDX_DATA = 8'h07;
   localparam logic [7:0] ADDR_ACCESS_CONTROL = 8'h18; // 4 * IDX_ACCESS_CONTROL
   localparam logic [7:0] ADDR_DATA = 8'h1C; // 4 * IDX_DATA
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   // access control field positions
   localparam int PHYAD_HI = 15;
   localparam int PHYAD_LO = 11;
   localparam int REGIDX_HI = 10;
   localparam int REGIDX_LO = 6;
   localparam int WNR_BIT = 1;
   localparam int PEND_BIT = 0;
   localparam int DATA_W = 16;
   // management clock timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int MDC_PERIOD_NS = 400; // least period of the management clock
   localparam int MDC_HALF_CYC = (MDC_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // clause 22 frame layout, bit 0 is the first bit on the wire
   localparam int FRAME_BITS = 64;
   localparam int OP_START = 34;
   localparam int REGIDX_START = 41;
   localparam int TA_START = 46;
   localparam int DATA_START = 48;
   localparam logic [31:0] PREAMBLE = 32'hFFFF_FFFF;
   localparam logic [1:0] START_CODE = 2'b01;
   localparam logic [1:0] OP_WRITE = 2'b01;
   localparam logic [1:0] OP_READ = 2'b10;
   localparam logic [1:0] TA_WRITE = 2'b10;

   typedef enum logic [0:0] {IDLE, FRAME} mgmt_state_t;

   // classic wishbone request from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;

   // whole state of the block
   typedef struct packed {
      mgmt_state_t state;
      logic [4:0] phy_addr;
      logic [4:0] phy_reg_index;
      logic write_not_read_select;
      logic access_pending;
      logic [15:0] data;
      logic ack;
      logic [31:0] rdat;
      logic [7:0] div;
      logic [6:0] bitn;
      logic [63:0] shift;
      logic [15:0] rx;
      logic mdc;
      logic mdo;
      logic oe;
   } mgmt_regs_t;
endpackage

// >>> phy_mgmt_register_access.sv
// wishbone register pair that runs clause 22 management cycles to the phy
`timescale 1ns/10ps
module phy_mgmt_register_access
(
   input wire logic clk_i, // 125 MHz system clock
   input wire logic rst_i, // synchronous reset, active high
   input wire phy_mgmt_pkg::wb_req_t wb_i, // wishbone request group
   output logic [31:0] wb_dat_o, // read data, registered
   output logic wb_ack_o, // one-cycle acknowledge
   output logic mdc_o, // management clock to the phy
   input wire logic mdio_i, // management data pin, input side
   output logic mdio_o, // management data pin, output side
   output logic mdio_oe_o // high while this block drives the pin
);
   phy_mgmt_pkg::mgmt_regs_t s_ff;
   phy_mgmt_pkg::mgmt_regs_t nxt_s;

   ////////////////////////////////////////////////////////////////////////
   // bus decode helpers
   logic req; // new request, not yet acknowledged
   logic [31:0] mask; // byte lane mask from sel
   logic [31:0] acc_rd; // access control read view
   logic [31:0] acc_wr; // access control after merge
   logic [31:0] dat_wr; // data register after merge

   assign req = wb_i.cyc & wb_i.stb & ~s_ff.ack;
   assign mask = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}}, {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
   // reserved fields fixed at zero
   assign acc_rd = {16'h0000, s_ff.phy_addr, s_ff.phy_reg_index, 4'h0,
                    s_ff.write_not_read_select, s_ff.access_pending};
   assign acc_wr = (acc_rd & ~mask) | (wb_i.dat & mask);
   assign dat_wr = ({16'h0000, s_ff.data} & ~mask) | (wb_i.dat & mask);

   ////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.ack = req; // answer one edge after the request is seen
      // register slave
      if (req)
      begin
         nxt_s.rdat = 32'h0000_0000; // unmapped addresses read zero
         if (wb_i.adr == phy_mgmt_pkg::ADDR_ACCESS_CONTROL)
         begin
            nxt_s.rdat = acc_rd;
            // writes while an access runs are dropped; software must poll first
            if (wb_i.we && !s_ff.access_pending)
            begin
               nxt_s.phy_addr = acc_wr[phy_mgmt_pkg::PHYAD_HI:phy_mgmt_pkg::PHYAD_LO];
               nxt_s.phy_reg_index =
                  acc_wr[phy_mgmt_pkg::REGIDX_HI:phy_mgmt_pkg::REGIDX_LO];
               nxt_s.write_not_read_select = acc_wr[phy_mgmt_pkg::WNR_BIT];
               nxt_s.access_pending = acc_wr[phy_mgmt_pkg::PEND_BIT];
            end
         end
         else if (wb_i.adr == phy_mgmt_pkg::ADDR_DATA)
         begin
            nxt_s.rdat = {16'h0000, s_ff.data};
            if (wb_i.we && !s_ff.access_pending)
            begin
               nxt_s.data = dat_wr[phy_mgmt_pkg::DATA_W-1:0];
            end
         end
      end
      // management frame engine
      case (s_ff.state)
         phy_mgmt_pkg::IDLE:
         begin
            // a frame starts only from a set pending bit
            if (s_ff.access_pending)
            begin
               nxt_s.state = phy_mgmt_pkg::FRAME;
               nxt_s.shift = {phy_mgmt_pkg::PREAMBLE, phy_mgmt_pkg::START_CODE,
                  s_ff.write_not_read_select ? phy_mgmt_pkg::OP_WRITE
                                             : phy_mgmt_pkg::OP_READ,
                  s_ff.phy_addr, s_ff.phy_reg_index, phy_mgmt_pkg::TA_WRITE,
                  s_ff.write_not_read_select ? s_ff.data : 16'h0000};
               nxt_s.mdo = 1'b1;
               nxt_s.oe = 1'b1;
               nxt_s.bitn = 7'h00;
               nxt_s.div = 8'h00;
               nxt_s.mdc = 1'b0;
            end
         end
         phy_mgmt_pkg::FRAME:
         begin
            if (s_ff.div == 8'(phy_mgmt_pkg::MDC_HALF_CYC - 1))
            begin
               nxt_s.div = 8'h00;
               nxt_s.mdc = ~s_ff.mdc;
               if (!s_ff.mdc)
               begin
                  // rising edge: the phy's data bits are sampled here
                  if (!s_ff.write_not_read_select &&
                      s_ff.bitn >= 7'(phy_mgmt_pkg::DATA_START))
                  begin
                     nxt_s.rx = {s_ff.rx[14:0], mdio_i};
                  end
               end
               else if (s_ff.bitn == 7'(phy_mgmt_pkg::FRAME_BITS - 1))
               begin
                  // last falling edge ends the access
                  nxt_s.state = phy_mgmt_pkg::IDLE;
                  nxt_s.access_pending = 1'b0;
                  nxt_s.oe = 1'b0;
                  nxt_s.mdo = 1'b0;
                  if (!s_ff.write_not_read_select)
                  begin
                     nxt_s.data = s_ff.rx; // same edge as pending clears
                  end
               end
               else
               begin
                  // falling edge: next bit onto the wire
                  nxt_s.bitn = s_ff.bitn + 7'h01;
                  nxt_s.shift = {s_ff.shift[62:0], 1'b0};
                  nxt_s.mdo = s_ff.shift[62];
                  // release the pin from turnaround on for reads
                  nxt_s.oe = s_ff.write_not_read_select ||
                     (s_ff.bitn + 7'h01 < 7'(phy_mgmt_pkg::TA_START));
               end
            end
            else
            begin
               nxt_s.div = s_ff.div + 8'h01;
            end
         end
         default:
         begin
            nxt_s.state = phy_mgmt_pkg::IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_ff <= '0; // both registers all zeros, nothing pending
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign wb_dat_o = s_ff.rdat;
   assign wb_ack_o = s_ff.ack;
   assign mdc_o = s_ff.mdc;
   assign mdio_o = s_ff.mdo;
   assign mdio_oe_o = s_ff.oe;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   localparam int PEND_MAX = phy_mgmt_pkg::FRAME_BITS * 2 * phy_mgmt_pkg::MDC_HALF_CYC + 4;
   logic [15:0] pend_cnt_ff; // cycles the pending bit has been high

   always_ff @(posedge clk_i)
   begin
      if (rst_i || !s_ff.access_pending)
      begin
         pend_cnt_ff <= 16'h0000;
      end
      else
      begin
         pend_cnt_ff <= pend_cnt_ff + 16'h0001;
      end
   end

   property p_frame_needs_pending;
      $rose(s_ff.state == phy_mgmt_pkg::FRAME) |-> $past(s_ff.access_pending);
   endproperty
   a_frame_needs_pending: assert property (p_frame_needs_pending)
      else $error("frame started without pending bit");

   property p_pending_held;
      (s_ff.state == phy_mgmt_pkg::FRAME) |-> s_ff.access_pending;
   endproperty
   a_pending_held: assert property (p_pending_held)
      else $error("pending bit dropped during frame");

   property p_pending_bounded;
      pend_cnt_ff <= 16'(PEND_MAX);
   endproperty
   a_pending_bounded: assert property (p_pending_bounded)
      else $error("pending bit never cleared");

   property p_read_data;
      ($fell(s_ff.access_pending) && !s_ff.write_not_read_select) |-> s_ff.data == s_ff.rx;
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("read data not in place when pending clears");

   property p_opcode;
      (s_ff.state == phy_mgmt_pkg::FRAME && s_ff.bitn == 7'(phy_mgmt_pkg::OP_START))
         |-> s_ff.mdo == !s_ff.write_not_read_select;
   endproperty
   a_opcode: assert property (p_opcode)
      else $error("opcode does not match write select");

   property p_reg_index;
      (s_ff.state == phy_mgmt_pkg::FRAME && s_ff.bitn == 7'(phy_mgmt_pkg::REGIDX_START))
         |-> s_ff.mdo == s_ff.phy_reg_index[4];
   endproperty
   a_reg_index: assert property (p_reg_index)
      else $error("register index not sent");

   property p_write_data;
      (s_ff.state == phy_mgmt_pkg::FRAME && s_ff.write_not_read_select &&
       s_ff.bitn == 7'(phy_mgmt_pkg::DATA_START)) |-> s_ff.mdo == s_ff.data[15];
   endproperty
   a_write_data: assert property (p_write_data)
      else $error("write data not sent");

   property p_read_release;
      (s_ff.state == phy_mgmt_pkg::FRAME && !s_ff.write_not_read_select &&
       s_ff.bitn >= 7'(phy_mgmt_pkg::TA_START)) |-> !mdio_oe_o;
   endproperty
   a_read_release: assert property (p_read_release)
      else $error("pin driven during read turnaround or data");

   property p_reserved_zero;
      (wb_ack_o && $past(wb_i.adr) == phy_mgmt_pkg::ADDR_ACCESS_CONTROL)
         |-> wb_dat_o[31:16] == 16'h0000 && wb_dat_o[5:2] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits read nonzero");

   property p_reset_zero;
      @(posedge clk_i) $past(rst_i) |-> !s_ff.access_pending && s_ff.data == 16'h0000;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("registers not zero after reset");

   c_read_done: cover property ($fell(s_ff.access_pending) && !s_ff.write_not_read_select);
   c_write_done: cover property ($fell(s_ff.access_pending) && s_ff.write_not_read_select);
   c_unmapped: cover property (req && wb_i.adr != phy_mgmt_pkg::ADDR_DATA &&
                               wb_i.adr != phy_mgmt_pkg::ADDR_ACCESS_CONTROL);
endmodule

// >>> phy_mgmt_phy_model.sv
// behavioural phy on the management pins, holding 32 registers of 16 bits
`timescale 1ns/10ps
module phy_mgmt_phy_model
#(
   parameter logic [4:0] PHY_ADDR = 5'h01 // address this phy answers to
)
(
   input wire logic mdc_i, // management clock from the block
   input wire logic mdio_i, // resolved data wire
   output logic mdio_o, // value driven while enabled
   output logic mdio_oe_o, // high while this model drives the wire
   output logic frame_ok_o, // preamble and start code seen
   output logic [1:0] op_o, // last operation code
   output logic [4:0] reg_o, // last register index
   output logic [15:0] wdata_o // last word written
);
   logic [15:0] mem [32]; // register file, known pattern at start
   logic [63:0] sh; // bits seen so far, newest in bit 0
   logic [4:0] pa; // last phy address
   int cnt; // rising edges counted in this frame
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      cnt = 0;
      sh = '0;
      pa = '0;
      {mdio_o, mdio_oe_o, frame_ok_o, op_o, reg_o, wdata_o} = '0;
      for (int i = 0; i < 32; i++) mem[i] = 16'hC000 | 16'(i);
   end
   // sample on rising mdc, where the block holds the wire steady
   always @(posedge mdc_i)
   begin
      sh <= {sh[62:0], mdio_i};
      cnt <= (cnt == 63) ? 0 : cnt + 1;
      if (cnt == 46)
      begin
         frame_ok_o <= (sh[45:12] == {32'hFFFF_FFFF, 2'b01});
         op_o <= sh[11:10];
         pa <= sh[9:5];
         reg_o <= sh[4:0];
      end
      if (cnt == 63 && op_o == 2'b01 && pa == PHY_ADDR)
      begin
         mem[reg_o] <= {sh[14:0], mdio_i};
         wdata_o <= {sh[14:0], mdio_i};
      end
   end
   // read answer changes on falling mdc; released wire is pulled up
   always @(negedge mdc_i)
   begin
      mdio_oe_o <= (op_o == 2'b10 && pa == PHY_ADDR && cnt >= 47);
      mdio_o <= (cnt >= 48) ? mem[reg_o][63 - cnt] : 1'b0;
   end
endmodule

// >>> phy_mgmt_register_access_tb.sv
// self-checking bench: wishbone master, pulled-up mdio wire and phy model
`timescale 1ns/10ps
module phy_mgmt_register_access_tb;
   localparam logic [7:0] AC = phy_mgmt_pkg::ADDR_ACCESS_CONTROL;
   localparam logic [7:0] DT = phy_mgmt_pkg::ADDR_DATA;
   logic clk_i, rst_i, wb_ack_o, mdc, mdo, mdoe, mdio, pdo, poe, fok;
   phy_mgmt_pkg::wb_req_t wb_q; // request from the master tasks
   logic [31:0] wb_dat_o, q; // read data and last word taken
   logic [1:0] pop;
   logic [4:0] preg;
   logic [15:0] pwd;
   int err_count, compares, t0;
   int cycles = 0; // clock edges since time zero, driven only by the counter below
   // pull-up wins when nobody drives
   assign mdio = mdoe ? mdo : (poe ? pdo : 1'b1);
   phy_mgmt_register_access i_phy_mgmt_register_access (.clk_i(clk_i), .rst_i(rst_i),
      .wb_i(wb_q), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mdc_o(mdc), .mdio_i(mdio),
      .mdio_o(mdo), .mdio_oe_o(mdoe));
   phy_mgmt_phy_model i_phy_mgmt_phy_model (.mdc_i(mdc), .mdio_i(mdio), .mdio_o(pdo),
      .mdio_oe_o(poe), .frame_ok_o(fok), .op_o(pop), .reg_o(preg), .wdata_o(pwd));
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_i = 0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) cycles <= cycles + 1;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // one classic cycle; request held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_q <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_q <= '0;
   endtask
   task automatic poll();
      q = 32'h0000_0001;
      while (q[0] !== 1'b0) xfer(1'b0, AC, 32'h0000_0000);
   endtask
   function automatic logic [31:0] acw(input logic [4:0] r, input logic w);
      return {16'h0000, 5'h01, r, 4'h0, w, 1'b1};
   endfunction
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      xfer(1'b0, AC, 32'h0000_0000);
      chk("control at reset", 32'h0000_0000, q);
      xfer(1'b0, DT, 32'h0000_0000);
      chk("data at reset", 32'h0000_0000, q);
      xfer(1'b0, 8'h20, 32'h0000_0000);
      chk("unmapped read", 32'h0000_0000, q);
      $display("test reset done");
   endtask
   // reserved bits dropped; no frame without the pending bit
   task automatic t_reserved();
      xfer(1'b1, AC, 32'hFFFF_0FFE);
      xfer(1'b0, AC, 32'h0000_0000);
      chk("control reserved", 32'h0000_0FC2, q);
      xfer(1'b1, DT, 32'hFFFF_1234);
      xfer(1'b0, DT, 32'h0000_0000);
      chk("data reserved", 32'h0000_1234, q);
      repeat (30) @(posedge clk_i);
      chk("no clock", 32'h0000_0000, {31'h0, mdc | mdoe});
      $display("test reserved done");
   endtask
   // write frame; a data write while pending must not leak
   task automatic t_write();
      xfer(1'b1, DT, 32'h0000_A5C3);
      xfer(1'b1, AC, acw(5'h05, 1'b1));
      t0 = cycles;
      xfer(1'b0, AC, 32'h0000_0000);
      chk("pending held", acw(5'h05, 1'b1), q);
      xfer(1'b1, DT, 32'h0000_1111);
      poll();
      chk("frame length", 32'h0000_0001, {31'h0, (cycles - t0) inside {[3190:3220]}});
      chk("written word", 32'h0000_A5C3, {16'h0, pwd});
      chk("write op", 32'h0000_0001, {30'h0, pop});
      chk("write index", 32'h0000_0005, {27'h0, preg});
      chk("frame form", 32'h0000_0001, {31'h0, fok});
      $display("test write done");
   endtask
   task automatic t_read();
      xfer(1'b1, AC, acw(5'h09, 1'b0));
      poll();
      xfer(1'b0, DT, 32'h0000_0000);
      chk("read word", 32'h0000_C009, q);
      chk("read op", 32'h0000_0002, {30'h0, pop});
      xfer(1'b1, AC, acw(5'h05, 1'b0));
      poll();
      xfer(1'b0, DT, 32'h0000_0000);
      chk("read back", 32'h0000_A5C3, q);
      $display("test read done");
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      wb_q = '0;
      rst_i = 1'b1;
      err_count = 0;
      compares = 0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_reserved();
      t_write();
      t_read();
      report_and_stop();
   end
   // three frames take under 10000 cycles
   initial
   begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      report_and_stop();
   end
endmodule
